// File: smsc_cfg.svh
// Constants for the SPI master serial controller
`ifndef SMSC_CFG_SVH
`define SMSC_CFG_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SMSC_SYS_HZ        32'd50000000
`define SMSC_REF_HZ        32'd12000000
`define SMSC_HALF_STEP     (32'd2 * `SMSC_REF_HZ)

// ----------------------------------------------------------------------------
// Fixed values
// ----------------------------------------------------------------------------
`define SMSC_MODE_SPI      3'h2
`define SMSC_BUSY_TOKEN    8'hff
`define SMSC_FIFO_DEPTH    3'h4
`define SMSC_BIT_LAST      3'h7

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SMSC_A_DATA        8'h00
`define SMSC_A_CFG         8'h04
`define SMSC_A_STAT        8'h08
`define SMSC_A_MODE        8'h0c
`define SMSC_A_LIN         8'h10
`define SMSC_A_EXP         8'h14
`define SMSC_A_PEND        8'h18
`define SMSC_A_IEN         8'h1c
`define SMSC_A_TRIG        8'h20
`define SMSC_A_DMA         8'h24

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SMSC_DMA_RXRST     0
`define SMSC_PEND_MASK     16'h1e1f
`define SMSC_RST_CFG       7'h00
`define SMSC_RST_MODE      3'h0
`define SMSC_RST_LIN       8'h00
`define SMSC_RST_EXP       4'h0
`define SMSC_RST_WORD      16'h0000
`define SMSC_RST_TRIG      3'h0
`define SMSC_RST_FLAGS     3'h6

`endif

// File: smsc_pkg.sv
// Types shared by the SPI master serial controller
package smsc_pkg;

    typedef struct packed {
        logic auto_en;
        logic rxdrv;
        logic mst;
        logic rpt;
        logic ord;
        logic pha;
        logic pol;
    } smsc_cfg_s;

    typedef struct packed {
        logic rx_ovf;
        logic tx_idle;
        logic tx_free;
        logic rx_val;
    } smsc_stat_s;

    typedef enum logic {
        SMSC_IDLE,
        SMSC_SHIFT
    } smsc_state_e;

endpackage

// File: smsc_top.sv
// SPI master serial controller: registers, FIFOs, clock generator and shifter
//
// Function
// - Master logic runs only with mode selector equal 2 and master bit set.
// - SCLK equals 12 MHz divided by (mantissa+1) times two to the exponent.
// - Zero divisors are legal and give the fastest 12 Mbps clock.
// - Bit order bit clear shifts MSB first, set shifts LSB first.
// - Transmit and receive characters each pass a four entry FIFO.
// - Data port write pushes transmit FIFO, read pops receive FIFO; DMA shares both.
// - Write with transmit FIFO and shifter empty clears the transmitter idle flag.
// - Transmit free clears when FIFO fills, sets when a character shifts out.
// - Transmitter idle sets when FIFO is empty and last character has left.
// - Received characters enter receive FIFO and set receive valid.
// - Character arriving with full receive FIFO is dropped, sets overrun flag and event.
// - Receive DMA error appears after FIFO drains; cleared by DMA reset or reload.
// - A character is received only while one is transmitted.
// - Empty FIFO with auto transmit sends last character or 0xFF per repeat bit.
// - Each automatic character start sets the transmit underrun pending flag.
// - Auto transmit disabled stops new receptions; received characters stay buffered.
// - Receive DMA completion does not imply an empty receive FIFO.
// - Idle, free and valid events fire on rising edge or high level per mode.
// - DMA buffer A/B completion events fire on falling edge of buffer active.
// - Receiver-driven set starts on transmit data only while receive FIFO has space; clear starts on transmit data even with the FIFO full.
// - Reading the data port also clears the receive overrun flag.
// - Interrupt mode bit 0 means edge triggered, 1 means level triggered.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`include "smsc_cfg.svh"

module smsc_top (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic        i_miso,
    output logic             o_sclk,
    output logic             o_mosi,
    input  wire logic        i_dma_tx_wr,
    input  wire logic [7:0]  i_dma_tx_data,
    output logic             o_dma_tx_ack,
    input  wire logic        i_dma_rx_rd,
    output logic      [7:0]  o_dma_rx_data,
    output logic             o_dma_rx_valid,
    input  wire logic [1:0]  i_tx_dma_buffer_active,
    input  wire logic [1:0]  i_rx_dma_buffer_active,
    input  wire logic        i_rx_dma_reload,
    output logic             o_rx_dma_error,
    output logic             o_irq
);
    import smsc_pkg::*;

    // ------------------------------------------------------------------------
    // Bit order helpers
    // ------------------------------------------------------------------------
    function automatic logic out_bit(input logic [7:0] b, input logic lsb);
        out_bit = lsb ? b[0] : b[7];
    endfunction

    function automatic logic [7:0] shift_out(input logic [7:0] b, input logic lsb);
        shift_out = lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d, input logic lsb);
        shift_in = lsb ? {d, b[7:1]} : {b[6:0], d};
    endfunction

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    smsc_cfg_s   cfg_r;
    smsc_stat_s  stat;
    smsc_state_e st_r;
    logic [2:0]  mode_r;
    logic [7:0]  lin_r;
    logic [3:0]  exp_r;
    logic [15:0] pend_r;
    logic [15:0] ien_r;
    logic [2:0]  trig_r;
    logic [7:0]  txm [0:3];
    logic [7:0]  rxm [0:3];
    logic [1:0]  tx_wp_r;
    logic [1:0]  tx_rp_r;
    logic [2:0]  tx_cnt_r;
    logic [1:0]  rx_wp_r;
    logic [1:0]  rx_rp_r;
    logic [2:0]  rx_cnt_r;
    logic        tx_idle_r;
    logic        tx_free_r;
    logic        rx_ovf_r;
    logic        ovf_wait_r;
    logic [31:0] acc_r;
    logic [22:0] hc_r;
    logic        half_r;
    logic [2:0]  bit_r;
    logic [7:0]  txsh_r;
    logic [7:0]  rxsh_r;
    logic [7:0]  last_r;
    logic        miso_m1_r;
    logic        miso_m2_r;
    logic        miso_m3_r;
    logic        miso_r;
    logic [2:0]  flag_prev_r;
    logic [3:0]  act_prev_r;
    logic [2:0]  flag_ev;

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    wire wr_data  = i_wr && (i_addr == `SMSC_A_DATA);
    wire rd_data  = i_rd && (i_addr == `SMSC_A_DATA);
    wire wr_pend  = i_wr && (i_addr == `SMSC_A_PEND);
    wire dma_rrst = i_wr && (i_addr == `SMSC_A_DMA) && i_wdata[`SMSC_DMA_RXRST];

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r  <= `SMSC_RST_CFG;
            mode_r <= `SMSC_RST_MODE;
            lin_r  <= `SMSC_RST_LIN;
            exp_r  <= `SMSC_RST_EXP;
            ien_r  <= `SMSC_RST_WORD;
            trig_r <= `SMSC_RST_TRIG;
        end else if (i_wr) begin
            if (i_addr == `SMSC_A_CFG) cfg_r <= i_wdata[6:0];
            if (i_addr == `SMSC_A_MODE) mode_r <= i_wdata[2:0];
            if (i_addr == `SMSC_A_LIN) lin_r <= i_wdata[7:0];
            if (i_addr == `SMSC_A_EXP) exp_r <= i_wdata[3:0];
            if (i_addr == `SMSC_A_IEN) ien_r <= i_wdata & `SMSC_PEND_MASK;
            if (i_addr == `SMSC_A_TRIG) trig_r <= i_wdata[2:0];
        end
    end

    // ------------------------------------------------------------------------
    // Transmit FIFO
    // ------------------------------------------------------------------------
    wire       active    = (mode_r == `SMSC_MODE_SPI) && cfg_r.mst;
    wire       tx_empty  = (tx_cnt_r == 3'h0);
    wire       tx_full   = (tx_cnt_r == `SMSC_FIFO_DEPTH);
    wire       sw_push   = wr_data && !tx_full;
    wire       dma_push  = i_dma_tx_wr && !wr_data && !tx_full;
    wire       tx_push   = sw_push || dma_push;
    wire [7:0] tx_pdata  = wr_data ? i_wdata[7:0] : i_dma_tx_data;
    wire       rx_empty  = (rx_cnt_r == 3'h0);
    wire       rx_full   = (rx_cnt_r == `SMSC_FIFO_DEPTH);
    wire       start_ok  = (!tx_empty || cfg_r.auto_en) && (!cfg_r.rxdrv || !rx_full);
    wire       load      = active && (st_r == SMSC_IDLE) && start_ok;
    wire       tx_pop    = load && !tx_empty;
    wire       underrun  = load && tx_empty;
    wire [7:0] auto_byte = cfg_r.rpt ? last_r : `SMSC_BUSY_TOKEN;
    wire [7:0] next_byte = tx_empty ? auto_byte : txm[tx_rp_r];

    always_ff @(posedge i_sys_clk) begin
        if (tx_push) txm[tx_wp_r] <= tx_pdata;
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_wp_r  <= 2'h0;
            tx_rp_r  <= 2'h0;
            tx_cnt_r <= 3'h0;
        end else begin
            tx_wp_r  <= tx_wp_r + {1'b0, tx_push};
            tx_rp_r  <= tx_rp_r + {1'b0, tx_pop};
            tx_cnt_r <= tx_cnt_r + {2'h0, tx_push} - {2'h0, tx_pop};
        end
    end

    // ------------------------------------------------------------------------
    // Serial clock generator
    // ------------------------------------------------------------------------
    wire [31:0] acc_sum   = acc_r + `SMSC_HALF_STEP;
    wire        ref_tick  = (acc_sum >= `SMSC_SYS_HZ);
    wire [22:0] div_full  = ({15'h0, lin_r} + 23'h1) << exp_r;
    wire [22:0] div_m1    = div_full - 23'h1;
    wire        half_tick = (st_r == SMSC_SHIFT) && ref_tick && (hc_r == div_m1);
    wire        fin       = half_tick && half_r && (bit_r == `SMSC_BIT_LAST);

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= 32'h0;
            hc_r  <= 23'h0;
        end else begin
            acc_r <= ref_tick ? acc_sum - `SMSC_SYS_HZ : acc_sum;
            if (load || half_tick) begin
                hc_r <= 23'h0;
            end else if ((st_r == SMSC_SHIFT) && ref_tick) begin
                hc_r <= hc_r + 23'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // MISO input filter
    // ------------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            miso_m1_r <= 1'b0;
            miso_m2_r <= 1'b0;
            miso_m3_r <= 1'b0;
            miso_r    <= 1'b0;
        end else begin
            miso_m1_r <= i_miso;
            miso_m2_r <= miso_m1_r;
            miso_m3_r <= miso_m2_r;
            if (miso_m2_r == miso_m3_r) miso_r <= miso_m3_r;
        end
    end

    // ------------------------------------------------------------------------
    // Shifter
    // ------------------------------------------------------------------------
    wire [7:0] rx_in = shift_in(rxsh_r, miso_r, cfg_r.ord);

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= SMSC_IDLE;
            half_r <= 1'b0;
            bit_r  <= 3'h0;
            txsh_r <= 8'h00;
            rxsh_r <= 8'h00;
            last_r <= 8'h00;
            o_sclk <= 1'b0;
            o_mosi <= 1'b0;
        end else if (!active) begin
            st_r   <= SMSC_IDLE;
            o_sclk <= cfg_r.pol;
        end else begin
            unique case (st_r)
                SMSC_IDLE: begin
                    o_sclk <= cfg_r.pol;
                    if (load) begin
                        st_r   <= SMSC_SHIFT;
                        half_r <= 1'b0;
                        bit_r  <= 3'h0;
                        last_r <= next_byte;
                        if (!cfg_r.pha) begin
                            o_mosi <= out_bit(next_byte, cfg_r.ord);
                            txsh_r <= shift_out(next_byte, cfg_r.ord);
                        end else begin
                            txsh_r <= next_byte;
                        end
                    end
                end
                SMSC_SHIFT: begin
                    if (half_tick) begin
                        o_sclk <= ~o_sclk;
                        half_r <= ~half_r;
                        if (!half_r) begin
                            if (!cfg_r.pha) begin
                                rxsh_r <= rx_in;
                            end else begin
                                o_mosi <= out_bit(txsh_r, cfg_r.ord);
                                txsh_r <= shift_out(txsh_r, cfg_r.ord);
                            end
                        end else begin
                            if (cfg_r.pha) begin
                                rxsh_r <= rx_in;
                            end else if (bit_r != `SMSC_BIT_LAST) begin
                                o_mosi <= out_bit(txsh_r, cfg_r.ord);
                                txsh_r <= shift_out(txsh_r, cfg_r.ord);
                            end
                            bit_r <= bit_r + 3'h1;
                            if (bit_r == `SMSC_BIT_LAST) st_r <= SMSC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------------------
    wire [7:0] rx_byte  = cfg_r.pha ? rx_in : rxsh_r;
    wire       rx_push  = fin && !rx_full;
    wire       overrun  = fin && rx_full;
    wire       sw_pop   = rd_data && !rx_empty;
    wire       dma_pop  = i_dma_rx_rd && !rd_data && !rx_empty;
    wire       rx_pop   = sw_pop || dma_pop;

    always_ff @(posedge i_sys_clk) begin
        if (rx_push) rxm[rx_wp_r] <= rx_byte;
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_wp_r  <= 2'h0;
            rx_rp_r  <= 2'h0;
            rx_cnt_r <= 3'h0;
        end else begin
            rx_wp_r  <= rx_wp_r + {1'b0, rx_push};
            rx_rp_r  <= rx_rp_r + {1'b0, rx_pop};
            rx_cnt_r <= rx_cnt_r + {2'h0, rx_push} - {2'h0, rx_pop};
        end
    end

    // ------------------------------------------------------------------------
    // Status flags and DMA side
    // ------------------------------------------------------------------------
    wire idle_set = fin && tx_empty && !tx_push;
    wire idle_clr = tx_push && tx_empty && (st_r == SMSC_IDLE);
    wire free_clr = (tx_cnt_r == 3'h3) && tx_push && !tx_pop;

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_idle_r      <= 1'b1;
            tx_free_r      <= 1'b1;
            rx_ovf_r       <= 1'b0;
            ovf_wait_r     <= 1'b0;
            o_rx_dma_error <= 1'b0;
            o_dma_tx_ack   <= 1'b0;
            o_dma_rx_valid <= 1'b0;
            o_dma_rx_data  <= 8'h00;
        end else begin
            if (idle_set) tx_idle_r <= 1'b1;
            else if (idle_clr) tx_idle_r <= 1'b0;
            if (fin) tx_free_r <= 1'b1;
            else if (free_clr) tx_free_r <= 1'b0;
            if (overrun) rx_ovf_r <= 1'b1;
            else if (rd_data) rx_ovf_r <= 1'b0;
            if (overrun) ovf_wait_r <= 1'b1;
            else if (rx_empty) ovf_wait_r <= 1'b0;
            if (ovf_wait_r && rx_empty) o_rx_dma_error <= 1'b1;
            else if (dma_rrst || i_rx_dma_reload) o_rx_dma_error <= 1'b0;
            o_dma_tx_ack   <= dma_push;
            o_dma_rx_valid <= dma_pop;
            if (dma_pop) o_dma_rx_data <= rxm[rx_rp_r];
        end
    end

    assign stat = '{rx_ovf: rx_ovf_r, tx_idle: tx_idle_r, tx_free: tx_free_r, rx_val: !rx_empty};

    // ------------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------------
    wire [2:0] flags = {stat.tx_idle, stat.tx_free, stat.rx_val};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_ev
            assign flag_ev[gi] = trig_r[gi] ? flags[gi] : flags[gi] && !flag_prev_r[gi];
        end
    endgenerate

    wire [3:0]  act_now  = {i_tx_dma_buffer_active, i_rx_dma_buffer_active};
    wire [3:0]  act_fall = act_prev_r & ~act_now;
    wire [15:0] pend_set = {3'h0, act_fall, 4'h0, underrun, overrun, flag_ev};
    wire [15:0] pend_clr = wr_pend ? i_wdata : `SMSC_RST_WORD;
    wire [15:0] pend_nxt = ((pend_r & ~pend_clr) | pend_set) & `SMSC_PEND_MASK;

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_prev_r <= `SMSC_RST_FLAGS;
            act_prev_r  <= 4'h0;
            pend_r      <= `SMSC_RST_WORD;
            o_irq       <= 1'b0;
        end else begin
            flag_prev_r <= flags;
            act_prev_r  <= act_now;
            pend_r      <= pend_nxt;
            o_irq       <= |(pend_r & ien_r);
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    wire [15:0] rd_mux =
        (i_addr == `SMSC_A_DATA) ? {8'h00, rx_empty ? 8'h00 : rxm[rx_rp_r]} :
        (i_addr == `SMSC_A_CFG)  ? {9'h000, cfg_r} :
        (i_addr == `SMSC_A_STAT) ? {12'h000, stat} :
        (i_addr == `SMSC_A_MODE) ? {13'h0000, mode_r} :
        (i_addr == `SMSC_A_LIN)  ? {8'h00, lin_r} :
        (i_addr == `SMSC_A_EXP)  ? {12'h000, exp_r} :
        (i_addr == `SMSC_A_PEND) ? pend_r :
        (i_addr == `SMSC_A_IEN)  ? ien_r :
        (i_addr == `SMSC_A_TRIG) ? {13'h0000, trig_r} :
        (i_addr == `SMSC_A_DMA)  ? {15'h0000, o_rx_dma_error} : 16'h0000;

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            o_rdata <= rd_mux;
        end else begin
            o_rdata <= 16'h0000;
        end
    end

endmodule

// File: smsc_top_chk.sv
// Port checker for the SPI master serial controller
module smsc_top_chk (
    input wire logic        i_sys_clk,
    input wire logic        i_rst_b,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        o_sclk,
    input wire logic        i_dma_tx_wr,
    input wire logic        o_dma_tx_ack,
    input wire logic        i_dma_rx_rd,
    input wire logic        o_dma_rx_valid,
    input wire logic        i_rx_dma_reload,
    input wire logic        o_rx_dma_error,
    input wire logic        o_irq
);
    logic [15:0] ien_r;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    // ----------------
    // Enable copy
    // ----------------
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ien_r <= 16'h0000;
        end else if (i_wr && i_addr == 8'h1c) begin
            ien_r <= i_wdata;
        end
    end

    rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside read slot");
    rd_unmap_a: assert property ($past(i_rd && i_addr > 8'h24) |-> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    sclk_rate_a: assert property ($changed(o_sclk) && !i_wr && !$past(i_wr) |=> $stable(o_sclk))
        else $error("serial clock faster than limit");
    tx_ack_a: assert property (o_dma_tx_ack |-> $past(i_dma_tx_wr && !(i_wr && i_addr == 8'h00)))
        else $error("dma push ack without push");
    rx_pop_a: assert property (o_dma_rx_valid |-> $past(i_dma_rx_rd && !(i_rd && i_addr == 8'h00)))
        else $error("dma pop valid without pop");
    reload_clr_a: assert property (i_rx_dma_reload |=> !o_rx_dma_error)
        else $error("dma error kept after reload");
    dma_rst_a: assert property (i_wr && i_addr == 8'h24 && i_wdata[0] |=> !o_rx_dma_error)
        else $error("dma error kept after reset bit");
    irq_mask_a: assert property (ien_r == 16'h0000 && $past(ien_r) == 16'h0000 |-> !o_irq)
        else $error("interrupt with all enables clear");
endmodule

bind smsc_top smsc_top_chk chk (.*);

// File: smsc_slave_model.sv
// Behavioural SPI slave answering each character
module smsc_slave_model (
    input  wire logic       i_sclk,
    input  wire logic       i_mosi,
    input  wire logic       i_sync,
    input  wire logic [2:0] i_fmt,
    input  wire logic [7:0] i_reply,
    output logic            o_miso = 1'b0,
    output logic [7:0]      o_got = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    int         edges = 0;
    int         n;
    logic       last = 1'b0;
    logic [7:0] sh = 8'h00;

    function automatic int pos(input int k);
        return i_fmt[2] ? k : 7 - k;
    endfunction

    // Sync high restarts the frame and presents the first bit
    always @(i_sclk or i_sync or i_reply or i_fmt) begin
        if (i_sync) begin
            edges = 0;
            o_miso = i_reply[pos(0)];
        end else if (i_sclk !== last) begin
            edges++;
            n = (edges - 1) / 2;
            if ((edges % 2) != i_fmt[1]) begin
                sh[pos(n)] = i_mosi;
            end else if (edges == 16) begin
                o_miso = i_reply[pos(0)];
            end else begin
                o_miso = i_reply[pos(i_fmt[1] ? n : n + 1)];
            end
            if (edges == 16) begin
                o_got = sh;
                edges = 0;
            end
        end
        last = i_sclk;
    end
endmodule

// File: smsc_top_tb.sv
// Self-checking bench for the SPI master serial controller
module smsc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_sys_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_dma_tx_wr = 1'b0;
    logic        i_dma_rx_rd = 1'b0, i_rx_dma_reload = 1'b0, sync = 1'b1, i_miso;
    logic        o_sclk, o_mosi, o_dma_tx_ack, o_dma_rx_valid, o_rx_dma_error, o_irq;
    logic [1:0]  i_tx_dma_buffer_active = 2'h0, i_rx_dma_buffer_active = 2'h0;
    logic [2:0]  fmt = 3'h0;
    logic [7:0]  i_addr = 8'h00, i_dma_tx_data = 8'h00, reply = 8'h3c, o_dma_rx_data, got;
    logic [15:0] i_wdata = 16'h0000, o_rdata, d;
    int          failures = 0, check_count = 0;

    always #10 i_sys_clk = ~i_sys_clk;
    smsc_top dut (.*);
    smsc_slave_model model (.i_sclk(o_sclk), .i_mosi(o_mosi), .i_sync(sync), .i_fmt(fmt),
                            .i_reply(reply), .o_miso(i_miso), .o_got(got));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 2000; k++) begin
            rd(8'h08);
            if (d[2] === 1'b1) return;
        end
        failures++;
        finish_test();
    endtask
    task automatic set_cfg(input logic [15:0] c);
        sync = 1'b1;
        fmt = c[2:0];
        wr(8'h04, c);
        repeat (3) @(posedge i_sys_clk);
        #1 sync = 1'b0;
    endtask

    task automatic t_reset();
        rd(8'h08);
        check(d, 16'h0006);
        rd(8'h18);
        check(d, 16'h0000);
        rd(8'h30);
        check(d, 16'h0000);
        wr(8'h0c, 16'h0002);
        wr(8'h10, 16'h0003);
        wr(8'h14, 16'h0001);
    endtask
    task automatic t_formats();
        for (int m = 0; m < 8; m++) begin
            reply = 8'h5c ^ 8'(m);
            set_cfg(16'h0010 | 16'(m));
            wr(8'h00, 16'h0096 + 16'(m));
            rd(8'h08);
            check(d[2], 1'b0);
            wait_idle();
            check(got, 8'h96 + 8'(m));
            check(o_sclk, fmt[0]);
            rd(8'h00);
            check(d, {8'h00, reply});
        end
    endtask
    task automatic t_overrun();
        reply = 8'h3c;
        set_cfg(16'h0010);
        for (int i = 0; i < 5; i++) wr(8'h00, 16'h00a0 + 16'(i));
        rd(8'h08);
        check(d[1], 1'b0);
        wait_idle();
        check(got, 8'ha4);
        rd(8'h08);
        check(d, 16'h000f);
        rd(8'h18);
        check(d & 16'h0008, 16'h0008);
        for (int i = 0; i < 5; i++) begin
            rd(8'h00);
            check(d, i < 4 ? 16'h003c : 16'h0000);
        end
        rd(8'h08);
        check(d, 16'h0006);
        check(o_rx_dma_error, 1'b1);
        wr(8'h24, 16'h0001);
        #1 check(o_rx_dma_error, 1'b0);
    endtask
    task automatic t_auto();
        wr(8'h1c, 16'h0010);
        for (int r = 1; r >= 0; r--) begin
            wr(8'h18, 16'hffff);
            wr(8'h04, 16'h0050 | 16'(r << 3));
            for (int n = 0; n < 600 && o_irq !== 1'b1; n++) @(posedge i_sys_clk);
            check(o_irq, 1'b1);
            if (o_irq !== 1'b1) finish_test();
            wr(8'h04, 16'h0010 | 16'(r << 3));
            repeat (300) @(posedge i_sys_clk);
            check(got, r ? 8'ha4 : 8'hff);
        end
        for (int i = 0; i < 3; i++) begin
            rd(8'h00);
            check(d, i < 2 ? 16'h003c : 16'h0000);
        end
        wr(8'h18, 16'hffff);
        repeat (2) @(posedge i_sys_clk);
        #1 check(o_irq, 1'b0);
    endtask
    task automatic t_dma();
        @(posedge i_sys_clk);
        i_dma_tx_wr <= 1'b1;
        i_dma_tx_data <= 8'h42;
        @(posedge i_sys_clk);
        i_dma_tx_wr <= 1'b0;
        #1 check(o_dma_tx_ack, 1'b1);
        wait_idle();
        check(got, 8'h42);
        @(posedge i_sys_clk);
        i_dma_rx_rd <= 1'b1;
        i_tx_dma_buffer_active <= 2'h3;
        i_rx_dma_buffer_active <= 2'h3;
        i_rx_dma_reload <= 1'b1;
        @(posedge i_sys_clk);
        i_dma_rx_rd <= 1'b0;
        i_tx_dma_buffer_active <= 2'h0;
        i_rx_dma_buffer_active <= 2'h0;
        i_rx_dma_reload <= 1'b0;
        #1 check({o_dma_rx_valid, o_dma_rx_data}, 9'h13c);
        rd(8'h18);
        check(d & 16'h1e00, 16'h1e00);
    endtask

    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        t_reset();
        t_formats();
        t_overrun();
        t_auto();
        t_dma();
        finish_test();
    end
endmodule
